// >>> common/epr_pkg.sv
// Constants for the exception priority and reset unit.
// Assumes one processor clock and an AHB-Lite register slave.
package epr_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_CAUSE    = 8'h04;
   localparam logic [7:0] ADDR_BADADDR  = 8'h08;
   localparam logic [7:0] ADDR_PAGE     = 8'h0c;
   localparam logic [7:0] ADDR_RETADDR  = 8'h10;
   localparam logic [7:0] ADDR_VECTOR   = 8'h14;
   localparam logic [7:0] ADDR_EVCOUNT  = 8'h18;
   localparam logic [7:0] ADDR_ZERO     = 8'h1c;
   // Status field positions
   localparam int ST_GIE  = 0;
   localparam int ST_USER = 1;
   localparam int ST_RST_IE = 2;
   localparam int ST_LVL_LO = 3;
   localparam int ST_LVL_W = 6;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0004;
   // ****************************************
   // Cause codes
   // ****************************************
   localparam logic [4:0] C_RESET = 5'h00;
   localparam logic [4:0] C_CPURST = 5'h01;
   localparam logic [4:0] C_IRQ = 5'h02;
   localparam logic [4:0] C_TRAP = 5'h03;
   localparam logic [4:0] C_UNIMPL = 5'h04;
   localparam logic [4:0] C_ILLEGAL = 5'h05;
   localparam logic [4:0] C_MIS_DATA = 5'h06;
   localparam logic [4:0] C_MIS_DEST = 5'h07;
   localparam logic [4:0] C_DIV = 5'h08;
   localparam logic [4:0] C_SUPV_IADDR = 5'h09;
   localparam logic [4:0] C_SUPV_INSTR = 5'h0a;
   localparam logic [4:0] C_SUPV_DADDR = 5'h0b;
   localparam logic [4:0] C_TLB_MISS = 5'h0c;
   localparam logic [4:0] C_TLB_EXEC = 5'h0d;
   localparam logic [4:0] C_TLB_READ = 5'h0e;
   localparam logic [4:0] C_TLB_WRITE = 5'h0f;
   localparam logic [4:0] C_MPU_I = 5'h10;
   localparam logic [4:0] C_MPU_D = 5'h11;
   // Source indices, highest priority first
   localparam int NSRC = 25;
   localparam int S_RESET = 0, S_HWBRK = 1, S_CPURST = 2, S_IIRQ = 3, S_NMI = 4;
   localparam int S_EIRQ = 5, S_SUPV_IA = 6, S_FTLB_I = 7, S_DTLB_I = 8;
   localparam int S_TLBX = 9, S_MPU_I = 10, S_SUPV_I = 11, S_TRAP = 12;
   localparam int S_ILL = 13, S_UNIMPL = 14, S_BRKI = 15, S_SUPV_DA = 16;
   localparam int S_MIS_D = 17, S_MIS_DST = 18, S_DIV = 19, S_FTLB_D = 20;
   localparam int S_DTLB_D = 21, S_TLBR = 22, S_TLBW = 23, S_MPU_D = 24;
   localparam logic [31:0] RET_OFFSET = 32'h0000_0004;
   // Reset sequence length: one cycle for the line invalidate
   localparam int INV_CYCLES = 1;
   typedef enum logic [1:0] {EPR_IN_RESET, EPR_INVALIDATE, EPR_RUN} epr_state_t;
endpackage

// >>> src/epr_prio_enc.sv
// Fixed priority picker: lowest set index wins.
// Assumes request bits already gated by configuration options.
`timescale 1ns/10ps
`default_nettype none
module epr_prio_enc #(
   parameter int N = 25
) (
   input  wire logic [N-1:0]         req,
   output logic                      any,
   output logic [$clog2(N)-1:0]      idx
);
   // ****************************************
   // Priority scan
   // ****************************************
   // Downward loop so the top ranked source is assigned last and wins
   always_comb begin
      any = |req;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = i[$clog2(N)-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/epr_unit.sv
// Exception ranking, cause and vector selection, and reset entry.
// Assumes fault pulses come from the pipeline one cycle each, precise.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module epr_unit #(
   parameter logic [31:0] RESET_VECTOR   = 32'h0000_0000,
   parameter logic [31:0] BREAK_VECTOR   = 32'h0000_0020,
   parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0040,
   parameter logic [31:0] FAST_TLB_VECTOR = 32'h0000_0060,
   parameter bit HAS_IIC = 1'b1,
   parameter bit HAS_EIC = 1'b1,
   parameter bit HAS_MMU = 1'b1,
   parameter bit HAS_MPU = 1'b0,
   parameter bit HAS_ILL_DET = 1'b1,
   parameter bit HAS_MEM_DET = 1'b1,
   parameter bit HAS_DIV_DET = 1'b1,
   parameter int VPN_W = 20
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Request side
   input  wire logic                  hw_break,
   input  wire logic                  cpu_reset_req,
   input  wire logic                  int_irq,
   input  wire logic                  ext_irq,
   input  wire logic                  ext_nmi,
   input  wire logic [5:0]            requested_irq_level,
   input  wire logic [31:0]           ext_handler_addr,
   // Fault side, one bit per instruction-related or data-related source
   input  wire logic [15:0]           fault_instr,
   input  wire logic [8:0]            fault_data,
   input  wire logic [31:0]           exception_return_addr,
   input  wire logic [31:0]           break_return_addr,
   input  wire logic [31:0]           fault_data_addr,
   input  wire logic [VPN_W-1:0]      fault_vpn,
   // Outputs to pipeline and cache
   output logic                       take,
   output logic [31:0]                target_pc,
   output logic                       icache_inv,
   output logic [31:0]                icache_inv_addr,
   output logic                       in_reset,
   output logic                       global_irq_enable,
   output logic                       supervisor,
   output logic [31:0]                zero_register
);
   // ****************************************
   // Request gathering
   // ****************************************
   epr_pkg::epr_state_t state;
   logic [31:0] status;
   logic [4:0]  cause;
   logic [31:0] bad_addr;
   logic [VPN_W-1:0] page_table_virtual_page;
   logic [31:0] assoc_addr;
   logic [31:0] vector_taken;
   logic [15:0] ev_count;
   logic [5:0]  current_irq_level;
   logic [epr_pkg::NSRC-1:0] req;
   logic        win_any;
   logic [4:0]  win;
   logic        running;

   assign running = (state == epr_pkg::EPR_RUN);
   assign current_irq_level = status[epr_pkg::ST_LVL_LO +: epr_pkg::ST_LVL_W];
   assign global_irq_enable = status[epr_pkg::ST_GIE];
   assign supervisor = !status[epr_pkg::ST_USER];
   assign zero_register = 32'h0000_0000;
   assign in_reset = !running;

   // Option gating of the configurable sources; faults arrive on any fetch
   always_comb begin
      req = '0;
      req[epr_pkg::S_HWBRK] = hw_break;
      req[epr_pkg::S_CPURST] = cpu_reset_req;
      req[epr_pkg::S_IIRQ] = HAS_IIC && int_irq && global_irq_enable;
      req[epr_pkg::S_NMI] = HAS_EIC && ext_nmi;
      req[epr_pkg::S_EIRQ] = HAS_EIC && ext_irq && global_irq_enable
                             && (requested_irq_level > current_irq_level);
      req[epr_pkg::S_SUPV_IA] = HAS_MMU && fault_instr[0];
      req[epr_pkg::S_FTLB_I] = HAS_MMU && fault_instr[1];
      req[epr_pkg::S_DTLB_I] = HAS_MMU && fault_instr[2];
      req[epr_pkg::S_TLBX] = HAS_MMU && fault_instr[3];
      req[epr_pkg::S_MPU_I] = HAS_MPU && fault_instr[4];
      req[epr_pkg::S_SUPV_I] = (HAS_MMU || HAS_MPU) && fault_instr[5];
      req[epr_pkg::S_TRAP] = fault_instr[6];
      req[epr_pkg::S_ILL] = (HAS_ILL_DET || HAS_MMU || HAS_MPU) && fault_instr[7];
      req[epr_pkg::S_UNIMPL] = fault_instr[8];
      req[epr_pkg::S_BRKI] = fault_instr[9];
      req[epr_pkg::S_SUPV_DA] = HAS_MMU && fault_data[0];
      req[epr_pkg::S_MIS_D] = (HAS_MEM_DET || HAS_MMU || HAS_MPU) && fault_data[1];
      req[epr_pkg::S_MIS_DST] = (HAS_MEM_DET || HAS_MMU || HAS_MPU) && fault_data[2];
      req[epr_pkg::S_DIV] = HAS_DIV_DET && fault_data[3];
      req[epr_pkg::S_FTLB_D] = HAS_MMU && fault_data[4];
      req[epr_pkg::S_DTLB_D] = HAS_MMU && fault_data[5];
      req[epr_pkg::S_TLBR] = HAS_MMU && fault_data[6];
      req[epr_pkg::S_TLBW] = HAS_MMU && fault_data[7];
      req[epr_pkg::S_MPU_D] = HAS_MPU && fault_data[8];
   end

   // Single ranking point so losers can never touch state
   epr_prio_enc #(
      .N (epr_pkg::NSRC)
   ) u_prio (
      .req (req),
      .any (win_any),
      .idx (win)
   );

   // ****************************************
   // Decode helpers
   // ****************************************
   // Cause for each source; a clear bit 5 marks no cause written
   function automatic logic [5:0] cause_of(input logic [4:0] s);
      case (s)
         5'd2: cause_of = {1'b1, epr_pkg::C_CPURST};
         5'd3, 5'd5: cause_of = {1'b1, epr_pkg::C_IRQ};
         5'd6: cause_of = {1'b1, epr_pkg::C_SUPV_IADDR};
         5'd7, 5'd8, 5'd20, 5'd21: cause_of = {1'b1, epr_pkg::C_TLB_MISS};
         5'd9: cause_of = {1'b1, epr_pkg::C_TLB_EXEC};
         5'd10: cause_of = {1'b1, epr_pkg::C_MPU_I};
         5'd11: cause_of = {1'b1, epr_pkg::C_SUPV_INSTR};
         5'd12: cause_of = {1'b1, epr_pkg::C_TRAP};
         5'd13: cause_of = {1'b1, epr_pkg::C_ILLEGAL};
         5'd14: cause_of = {1'b1, epr_pkg::C_UNIMPL};
         5'd16: cause_of = {1'b1, epr_pkg::C_SUPV_DADDR};
         5'd17: cause_of = {1'b1, epr_pkg::C_MIS_DATA};
         5'd18: cause_of = {1'b1, epr_pkg::C_MIS_DEST};
         5'd19: cause_of = {1'b1, epr_pkg::C_DIV};
         5'd22: cause_of = {1'b1, epr_pkg::C_TLB_READ};
         5'd23: cause_of = {1'b1, epr_pkg::C_TLB_WRITE};
         5'd24: cause_of = {1'b1, epr_pkg::C_MPU_D};
         default: cause_of = 6'h00; // Breaks and NMI leave cause alone
      endcase
   endfunction

   // Vector for each source
   function automatic logic [31:0] vector_of(input logic [4:0] s, input logic [31:0] rha);
      case (s)
         5'd0, 5'd2: vector_of = RESET_VECTOR;
         5'd1, 5'd15: vector_of = BREAK_VECTOR;
         5'd4, 5'd5: vector_of = rha;
         5'd7, 5'd20: vector_of = FAST_TLB_VECTOR;
         default: vector_of = GENERAL_VECTOR;
      endcase
   endfunction

   logic [5:0]  win_cause;
   logic [31:0] win_vector;
   logic        win_baddr;
   logic        win_vpn;
   logic        win_ret;
   logic        win_brk;
   assign win_cause = cause_of(win);
   assign win_vector = vector_of(win, ext_handler_addr);
   // Data-side faults that record the data or destination address
   assign win_baddr = (win >= 5'd16);
   assign win_vpn = (win >= 5'd7 && win <= 5'd9) || (win >= 5'd20 && win <= 5'd23);
   assign win_ret = (win >= 5'd3 && win <= 5'd14) || (win == 5'd19);
   assign win_brk = (win == 5'd15);
   assign take = running && win_any;

   // ****************************************
   // Reset entry sequence
   // ****************************************
   // Invalidate the reset line before the first fetch so it comes uncached
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= epr_pkg::EPR_IN_RESET;
      end else begin
         case (state)
            epr_pkg::EPR_IN_RESET: state <= epr_pkg::EPR_INVALIDATE;
            epr_pkg::EPR_INVALIDATE: state <= epr_pkg::EPR_RUN;
            epr_pkg::EPR_RUN: begin
               if (take && win == 5'(epr_pkg::S_CPURST)) begin
                  state <= epr_pkg::EPR_INVALIDATE;
               end
            end
            default: state <= epr_pkg::EPR_IN_RESET;
         endcase
      end
   end
   assign icache_inv = (state == epr_pkg::EPR_INVALIDATE);
   assign icache_inv_addr = RESET_VECTOR;

   // Fetch target: reset vector leaves invalidate state, else the winner
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target_pc <= 32'h0000_0000;
      end else if (state == epr_pkg::EPR_INVALIDATE) begin
         target_pc <= RESET_VECTOR;
      end else if (take) begin
         target_pc <= win_vector;
      end
   end

   // ****************************************
   // Status register
   // ****************************************
   // Software writes steer interrupt enable and level
   logic wr_pend;
   logic [7:0] addr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= epr_pkg::STATUS_RESET;
      end else if (take && (win == 5'(epr_pkg::S_CPURST))) begin
         status <= epr_pkg::STATUS_RESET;
      end else if (take) begin
         status[epr_pkg::ST_GIE] <= 1'b0;
         status[epr_pkg::ST_USER] <= 1'b0;
      end else if (wr_pend && addr_q == epr_pkg::ADDR_STATUS) begin
         status <= {23'h00_0000, hwdata[8:0]};
      end
   end

   // ****************************************
   // Cause, addresses and counters
   // ****************************************
   // Only the winner updates, so lower sources in the same cycle are lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause <= epr_pkg::C_RESET;
      end else if (take && win_cause[5]) begin
         cause <= win_cause[4:0];
      end
   end // Break and NMI fall through untouched

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bad_addr <= 32'h0000_0000;
      end else if (take && win_baddr) begin
         bad_addr <= fault_data_addr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_table_virtual_page <= '0;
      end else if (take && win_vpn) begin
         page_table_virtual_page <= fault_vpn;
      end
   end

   // Precise: address of the faulting instruction so it can re-run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         assoc_addr <= 32'h0000_0000;
      end else if (take && win_ret) begin
         assoc_addr <= exception_return_addr - epr_pkg::RET_OFFSET;
      end else if (take && win_brk) begin
         assoc_addr <= break_return_addr - epr_pkg::RET_OFFSET;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_taken <= 32'h0000_0000;
         ev_count <= 16'h0000;
      end else if (take) begin
         vector_taken <= win_vector;
         ev_count <= ev_count + 16'h0001;
      end
   end

   // ****************************************
   // AHB-Lite slave, zero wait, always OKAY
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite && (hsize == 3'h2); // Word writes only
         addr_q <= haddr[7:0];
      end
   end

   // Read data registered at the address phase for a flop-driven output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            epr_pkg::ADDR_STATUS: hrdata <= status;
            epr_pkg::ADDR_CAUSE: hrdata <= {27'h000_0000, cause};
            epr_pkg::ADDR_BADADDR: hrdata <= bad_addr;
            epr_pkg::ADDR_PAGE: hrdata <= 32'(page_table_virtual_page);
            epr_pkg::ADDR_RETADDR: hrdata <= assoc_addr;
            epr_pkg::ADDR_VECTOR: hrdata <= vector_taken;
            epr_pkg::ADDR_EVCOUNT: hrdata <= {16'h0000, ev_count};
            default: hrdata <= 32'h0000_0000; // Unmapped and zero register
         endcase
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // Checks
   // ****************************************
   a_cause_reset_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'(epr_pkg::S_CPURST) |=> cause == epr_pkg::C_CPURST)
      else $error("cpu reset cause wrong");
   a_cause_break_kept: assert property (@(posedge hclk) disable iff (!hresetn)
      take && (win == 5'd1 || win == 5'd4 || win == 5'd15) |=> $stable(cause))
      else $error("cause changed on break or nmi");
   a_target_break: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win_brk |=> target_pc == BREAK_VECTOR)
      else $error("break vector wrong");
   a_eirq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'd5 |-> requested_irq_level > current_irq_level)
      else $error("irq taken below level");
   a_maskable_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'd3 |-> status[epr_pkg::ST_GIE] == 1'b1)
      else $error("maskable irq with enable clear");
   a_ret_minus_four: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'(epr_pkg::S_TRAP) |=>
         assoc_addr == $past(exception_return_addr) - epr_pkg::RET_OFFSET)
      else $error("return address not minus 4");
   sequence s_inv;
      icache_inv ##1 (target_pc == RESET_VECTOR);
   endsequence
   a_reset_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(icache_inv) |-> s_inv)
      else $error("reset fetch not after invalidate");
   a_fast_tlb_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'd7 |=> target_pc == FAST_TLB_VECTOR && cause == epr_pkg::C_TLB_MISS)
      else $error("fast tlb miss vector wrong");
   a_status_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'(epr_pkg::S_CPURST) |=> status == epr_pkg::STATUS_RESET)
      else $error("status not at reset value");
   a_misalign_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      take && win == 5'd17 |=> bad_addr == $past(fault_data_addr))
      else $error("bad address not recorded");
endmodule
`default_nettype wire

// >>> verif/epr_eic_model.sv
// Request-side partner: interrupt controller and debug module.
// Assumes the bench commands each request; the unit's take ends it.
`timescale 1ns/10ps
`default_nettype none
module epr_eic_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        take,
   input  wire logic        go,
   input  wire logic        drop,
   input  wire logic [1:0]  kind,
   input  wire logic [5:0]  lvl,
   input  wire logic [31:0] addr,
   output logic             ext_irq,
   output logic             ext_nmi,
   output logic             hw_break,
   output logic [5:0]       requested_irq_level,
   output logic [31:0]      ext_handler_addr
);
   // Held until taken or withdrawn; idle data toggles so stale values never match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ext_irq, ext_nmi, hw_break} <= 3'h0;
         requested_irq_level <= 6'h00;
         ext_handler_addr <= 32'h0000_0000;
      end else if (go) begin
         {ext_irq, ext_nmi, hw_break} <= {kind == 2'h1, kind == 2'h2, kind == 2'h3};
         requested_irq_level <= lvl;
         ext_handler_addr <= addr;
      end else if (take || drop) begin
         {ext_irq, ext_nmi, hw_break} <= 3'h0;
      end else if (!(ext_irq || ext_nmi)) begin
         requested_irq_level <= ~requested_irq_level;
         ext_handler_addr <= ~ext_handler_addr;
      end
   end
endmodule
`default_nettype wire

// >>> verif/exception_priority_reset_unit_bench.sv
// Self-checking bench: reset entry, fault table, priority, interrupts.
// Assumes the unit's slave always ready and one exception taken a cycle.
`timescale 1ns/10ps
`default_nettype none
module exception_priority_reset_unit_bench;
   localparam logic [31:0] RV = 32'h0000_0100;
   localparam logic [31:0] BV = 32'h0000_0200;
   localparam logic [31:0] GV = 32'h0000_0300;
   localparam logic [31:0] FV = 32'h0000_0400;
   logic        hclk, hresetn, hsel, hwrite, cpu_reset_req, int_irq, go, drop;
   logic        hreadyout, take, icache_inv, in_reset, gie, supv, ext_irq, ext_nmi, hw_break;
   logic [1:0]  htrans, kind;
   logic [2:0]  hsize;
   logic [5:0]  lvl, req_lvl;
   logic [15:0] fault_instr;
   logic [8:0]  fault_data;
   logic [31:0] haddr, hwdata, hrdata, era, ba, fda, addr, handler, target_pc, inv_addr;
   logic [31:0] zero_reg, rd, exp_c;
   logic        hresp;
   logic [4:0]  cz [19] = '{5'h09, 5'h0c, 5'h0c, 5'h0d, 5'h10, 5'h0a, 5'h03, 5'h05, 5'h04,
                           5'h1f, 5'h0b, 5'h06, 5'h07, 5'h08, 5'h0c, 5'h0c, 5'h0e, 5'h0f, 5'h11};
   int          n_mismatch, check_count, i;
   epr_unit #(.RESET_VECTOR(RV), .BREAK_VECTOR(BV), .GENERAL_VECTOR(GV),
      .FAST_TLB_VECTOR(FV), .HAS_MPU(1'b1)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .hw_break(hw_break), .cpu_reset_req(cpu_reset_req), .int_irq(int_irq),
      .ext_irq(ext_irq), .ext_nmi(ext_nmi), .requested_irq_level(req_lvl),
      .ext_handler_addr(handler), .fault_instr(fault_instr), .fault_data(fault_data),
      .exception_return_addr(era), .break_return_addr(ba), .fault_data_addr(fda),
      .fault_vpn(era[19:0]), .take(take), .target_pc(target_pc), .icache_inv(icache_inv),
      .icache_inv_addr(inv_addr), .in_reset(in_reset), .global_irq_enable(gie),
      .supervisor(supv), .zero_register(zero_reg));
   epr_eic_model PEER (.hclk(hclk), .hresetn(hresetn), .take(take), .go(go), .drop(drop),
      .kind(kind), .lvl(lvl), .addr(addr), .ext_irq(ext_irq), .ext_nmi(ext_nmi),
      .hw_break(hw_break), .requested_irq_level(req_lvl), .ext_handler_addr(handler));
   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Bounded wait for ready; a hung slave ends the run
   task edge_ready;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 50) begin
            n_mismatch++;
            wrap_up;
         end
         @(posedge hclk);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {24'h00_0000, a};
      edge_ready;
      {hsel, htrans} <= 3'h0;
      hwdata <= d;
      edge_ready;
      rd = hrdata;
   endtask
   // Exception registers land at the edge after take
   task exc(input logic [31:0] c, input logic [31:0] pc);
      repeat (2) @(posedge hclk);
      bus(1'b0, epr_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk(rd, c);
      chk(target_pc, pc);
   endtask
   task fire(input logic [1:0] k, input logic [5:0] l, input logic [31:0] a);
      {go, kind, lvl, addr} <= {1'b1, k, l, a};
      @(posedge hclk);
      go <= 1'b0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      @(posedge hclk);
      @(negedge hclk);
      chk(32'(icache_inv), 32'h0000_0001);
      chk(inv_addr, RV);
      @(posedge hclk);
      @(negedge hclk);
      chk({target_pc[31:1], in_reset}, RV);
      chk({30'h0000_0000, supv, gie}, 32'h0000_0002);
      chk(32'(hresp), 32'h0000_0000);
      @(posedge hclk);
      bus(1'b0, epr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      bus(1'b0, epr_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, epr_pkg::ADDR_ZERO, 32'h0000_0000);
      chk(rd | zero_reg, 32'h0000_0000);
   endtask
   // Every fetch and data fault alone; break instruction keeps the cause
   task t_faults;
      for (i = 0; i < 19; i++) begin
         era <= 32'h0000_1000 + 32'(i * 16);
         ba <= 32'h0000_2000 + 32'(i * 16);
         fda <= 32'h0000_3001 + 32'(i);
         if (i < 10) fault_instr <= 16'h0001 << i;
         else fault_data <= 9'h001 << (i - 10);
         @(posedge hclk);
         {fault_instr, fault_data} <= 25'h000_0000;
         if (cz[i] != 5'h1f) exp_c = {27'h000_0000, cz[i]};
         exc(exp_c, (i == 9) ? BV : (i == 1 || i == 14) ? FV : GV);
         bus(1'b0, epr_pkg::ADDR_RETADDR, 32'h0000_0000);
         if (i < 10) chk(rd, ((i == 9) ? ba : era) - 32'h0000_0004);
         bus(1'b0, epr_pkg::ADDR_BADADDR, 32'h0000_0000);
         if (cz[i] inside {5'h06, 5'h07, 5'h11}) chk(rd, fda);
         bus(1'b0, epr_pkg::ADDR_PAGE, 32'h0000_0000);
         if (cz[i] inside {[5'h0c:5'h0f]}) chk(rd, {12'h000, era[19:0]});
      end
   endtask
   task t_prio;
      {fault_instr, fault_data} <= {16'h00c0, 9'h1ff};
      @(posedge hclk);
      {fault_instr, fault_data} <= 25'h000_0000;
      exc(32'h0000_0003, GV);
      bus(1'b0, epr_pkg::ADDR_BADADDR, 32'h0000_0000);
      chk(rd, 32'h0000_3013);
   endtask
   task t_irq;
      bus(1'b1, epr_pkg::ADDR_STATUS, 32'h0000_0019);
      bus(1'b0, epr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0019);
      fire(2'h1, 6'h03, 32'h0000_5000);
      exc(32'h0000_0003, GV);
      {drop, go} <= 2'h2;
      @(posedge hclk);
      drop <= 1'b0;
      fire(2'h1, 6'h04, 32'h0000_5000);
      exc(32'h0000_0002, 32'h0000_5000);
      fire(2'h1, 6'h3f, 32'h0000_5800);
      exc(32'h0000_0002, 32'h0000_5000);
      chk(32'(gie), 32'h0000_0000);
      {drop, go} <= 2'h2;
      @(posedge hclk);
      drop <= 1'b0;
      fire(2'h2, 6'h00, 32'h0000_6000);
      exc(32'h0000_0002, 32'h0000_6000);
      fire(2'h3, 6'h00, 32'h0000_0000);
      exc(32'h0000_0002, BV);
      bus(1'b1, epr_pkg::ADDR_STATUS, 32'h0000_0001);
      {int_irq, era} <= {1'b1, 32'h0000_7000};
      @(posedge hclk);
      int_irq <= 1'b0;
      exc(32'h0000_0002, GV);
      bus(1'b0, epr_pkg::ADDR_RETADDR, 32'h0000_0000);
      chk(rd, 32'h0000_6ffc);
   endtask
   task t_cpurst;
      cpu_reset_req <= 1'b1;
      @(posedge hclk);
      cpu_reset_req <= 1'b0;
      @(negedge hclk);
      chk({30'h0000_0000, icache_inv, in_reset}, 32'h0000_0003);
      repeat (3) @(posedge hclk);
      exc(32'h0000_0001, RV);
      bus(1'b0, epr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      bus(1'b0, epr_pkg::ADDR_VECTOR, 32'h0000_0000);
      chk(rd, RV);
      bus(1'b0, epr_pkg::ADDR_EVCOUNT, 32'h0000_0000);
      chk(rd, 32'h0000_0019);
   endtask
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, cpu_reset_req, int_irq, go, drop, htrans, kind, hsize, lvl} = '0;
      {haddr, hwdata, era, ba, fda, addr, fault_instr, fault_data} = '0;
      {n_mismatch, check_count, exp_c} = '0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_faults;
      t_prio;
      t_irq;
      t_cpurst;
      wrap_up;
   end
   // Hang guard
   initial begin
      #2000000;
      n_mismatch++;
      wrap_up;
   end
endmodule
`default_nettype wire
